// ### hw/etsss_pkg.sv
// constants, carriers and states shared by the timestamp sample store
package etsss_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] OFS_NS7         = 12'h59c;  // seventh sample nanoseconds
  localparam logic [11:0] OFS_SEC7        = 12'h5a0;  // seventh sample seconds
  localparam logic [11:0] OFS_PH7         = 12'h5a4;  // seventh sample phase slot
  localparam logic [11:0] OFS_NS8         = 12'h5a8;  // eighth sample nanoseconds
  localparam logic [11:0] OFS_SEC8        = 12'h5ac;  // eighth sample seconds
  localparam logic [11:0] OFS_UNIT_INDEX  = 12'h5b4;  // unit index pointer register

  // ==========================================================
  // field layout and reset values
  localparam int unsigned UNIT_PTR_BIT    = 8;        // pointer bit in unit index register
  localparam int unsigned POL_BIT         = 30;       // edge polarity bit
  localparam int unsigned NS_W            = 30;       // nanoseconds field width
  localparam int unsigned PHASE_W         = 3;        // phase slot width
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic        RST_UNIT_PTR    = 1'b0;

  // ==========================================================
  // record memory geometry: two units times two samples
  localparam int unsigned REC_DEPTH       = 4;
  localparam int unsigned REC_AW          = 2;

  // ==========================================================
  // phase codes for the five 8ns slots of one 40ns reference period
  localparam logic [2:0]  CODE_SLOT0      = 3'h0;     // 0ns
  localparam logic [2:0]  CODE_SLOT1      = 3'h1;     // 8ns
  localparam logic [2:0]  CODE_SLOT2      = 3'h2;     // 16ns, reserved range avoided
  localparam logic [2:0]  CODE_SLOT3      = 3'h3;     // 24ns
  localparam logic [2:0]  CODE_SLOT4      = 3'h4;     // 32ns

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
  } etsss_apb_req_t;

  typedef struct packed {
    logic              valid;       // one-cycle capture strobe
    logic              unit;        // timestamp unit that captured
    logic              eighth;      // 0: seventh sample, 1: eighth sample
    logic              rising;      // captured edge was rising
    logic [29:0]       nanoseconds; // time counter nanoseconds
    logic [31:0]       seconds;     // time counter seconds
    logic [2:0]        slot;        // 8ns slot index 0..4
  } etsss_capture_t;

  typedef struct packed {
    logic              polarity;
    logic [29:0]       nanoseconds;
    logic [31:0]       seconds;
    logic [2:0]        phase_code;
  } etsss_record_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH  = 2'b01,
    ST_ANSWER = 2'b10
  } etsss_state_t;

endpackage

// ### hw/etsss_record_mem.sv
// small record memory holding one capture record per unit and sample
`timescale 1ns/10ps
module etsss_record_mem (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  clk_en,
  // write port
  input  wire logic                  wr_en,
  input  wire logic [1:0]            wr_addr,
  input  wire etsss_pkg::etsss_record_t wr_data,
  // read port, data registered
  input  wire logic [1:0]            rd_addr,
  output etsss_pkg::etsss_record_t   rd_data
);
  import etsss_pkg::*;

  etsss_record_t mem_r [REC_DEPTH];  // record storage

  // ==========================================================
  // storage entries, cleared at reset
  genvar gi;
  for (gi = 0; gi < REC_DEPTH; gi++) begin : g_entry
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        mem_r[gi] <= '0;
      end else if (clk_en && wr_en && (wr_addr == REC_AW'(gi))) begin
        mem_r[gi] <= wr_data;
      end
    end
  end

  // ==========================================================
  // registered read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // etsss_record_mem

// ### hw/etsss_top.sv
// seventh and eighth event timestamp sample store with apb readout
`timescale 1ns/10ps
module etsss_top (
  // clock, reset, enable
  input  wire logic                     CLOCK,
  input  wire logic                     RSTN,
  input  wire logic                     CLK_EN,
  // apb slave
  input  wire etsss_pkg::etsss_apb_req_t APB_REQ,
  output logic                          PREADY,
  output logic [31:0]                   PRDATA,
  output logic                          PSLVERR,
  // capture input from edge detector and time counter
  input  wire etsss_pkg::etsss_capture_t CAPTURE,
  // current unit pointer
  output logic                          UNIT_POINTER
);
  import etsss_pkg::*;

  etsss_state_t  state_r;        // apb answer sequencer
  etsss_state_t  state_nxt;      // next sequencer state
  logic          unit_ptr_r;     // selected timestamp unit
  logic [31:0]   prdata_r;       // registered read data
  logic          slverr_r;       // registered error flag
  logic          setup_hit;      // setup phase seen while idle
  logic [1:0]    rd_index;       // record index for the read
  logic [1:0]    wr_index;       // record index for the capture
  etsss_record_t wr_rec;         // record built from capture
  etsss_record_t rd_rec;         // record read from memory

  // ==========================================================
  // helpers
  function automatic logic is_eighth(input logic [11:0] a);
    is_eighth = (a == OFS_NS8) || (a == OFS_SEC8);
  endfunction

  function automatic logic is_sample(input logic [11:0] a);
    is_sample = (a == OFS_NS7) || (a == OFS_SEC7) || (a == OFS_PH7) ||
                (a == OFS_NS8) || (a == OFS_SEC8);
  endfunction

  function automatic logic [2:0] encode_slot(input logic [2:0] slot);
    case (slot)
      3'h0:    encode_slot = CODE_SLOT0;
      3'h1:    encode_slot = CODE_SLOT1;
      3'h2:    encode_slot = CODE_SLOT2;
      3'h3:    encode_slot = CODE_SLOT3;
      3'h4:    encode_slot = CODE_SLOT4;
      default: encode_slot = CODE_SLOT0;  // out of range slot reads as first
    endcase
  endfunction

  // word presented at an address, reserved bits forced to zero
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input etsss_record_t r,
                                            input logic ptr);
    logic [31:0] w;
    w = RST_WORD;
    case (a)
      OFS_NS7, OFS_NS8: begin
        w[POL_BIT]    = r.polarity;
        w[NS_W-1:0]   = r.nanoseconds;
      end
      OFS_SEC7, OFS_SEC8: begin
        w             = r.seconds;
      end
      OFS_PH7: begin
        w[PHASE_W-1:0] = r.phase_code;
      end
      OFS_UNIT_INDEX: begin
        w[UNIT_PTR_BIT] = ptr;
      end
      default: begin
        w = RST_WORD;
      end
    endcase
    read_word = w;
  endfunction

  // ==========================================================
  // capture path into the record memory
  always_comb begin
    wr_index = {CAPTURE.unit, CAPTURE.eighth};
    wr_rec.polarity    = CAPTURE.rising;
    wr_rec.nanoseconds = CAPTURE.nanoseconds;
    wr_rec.seconds     = CAPTURE.seconds;
    // eighth sample phase is not presented here, so stored as zero
    wr_rec.phase_code  = CAPTURE.eighth ? CODE_SLOT0 : encode_slot(CAPTURE.slot);
  end

  // read index follows the unit pointer and the sample group
  assign rd_index  = {unit_ptr_r, is_eighth(APB_REQ.paddr)};
  // penable may already be high when the setup cycle fell on a frozen edge
  assign setup_hit = (state_r == ST_IDLE) && APB_REQ.psel;

  etsss_record_mem u_mem (
    .clock   (CLOCK),
    .rstn    (RSTN),
    .clk_en  (CLK_EN),
    .wr_en   (CAPTURE.valid),   // only captures write; bus writes never do
    .wr_addr (wr_index),
    .wr_data (wr_rec),
    .rd_addr (rd_index),
    .rd_data (rd_rec)
  );

  // ==========================================================
  // apb sequencer: setup, fetch, answer
  always_comb begin
    case (state_r)
      ST_IDLE:   state_nxt = setup_hit ? ST_FETCH : ST_IDLE;
      ST_FETCH:  state_nxt = ST_ANSWER;
      ST_ANSWER: state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // read data and error, latched in the fetch cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_r <= RST_WORD;
      slverr_r <= 1'b0;
    end else if (CLK_EN && (state_r == ST_FETCH)) begin
      // writes return zero data; sample registers ignore them
      prdata_r <= APB_REQ.pwrite ? RST_WORD
                                 : read_word(APB_REQ.paddr, rd_rec, unit_ptr_r);
      slverr_r <= !(is_sample(APB_REQ.paddr) || (APB_REQ.paddr == OFS_UNIT_INDEX));
    end
  end

  // ==========================================================
  // unit index pointer, written at the completing edge
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      unit_ptr_r <= RST_UNIT_PTR;
    end else if (CLK_EN && (state_r == ST_ANSWER) && APB_REQ.pwrite &&
                 (APB_REQ.paddr == OFS_UNIT_INDEX)) begin
      unit_ptr_r <= APB_REQ.pwdata[UNIT_PTR_BIT];
    end
  end

  // ready only on an enabled edge, so a frozen answer cycle never completes
  assign PREADY       = (state_r == ST_ANSWER) && CLK_EN;
  assign PRDATA       = prdata_r;
  assign PSLVERR      = PREADY && slverr_r;
  assign UNIT_POINTER = unit_ptr_r;

  // ==========================================================
  // assertion helpers: shadow records and expected read word
  etsss_record_t h_rec_r [REC_DEPTH];  // shadow of stored records
  logic [31:0]   h_exp_r;              // expected answer word

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < REC_DEPTH; i++) begin
        h_rec_r[i] <= '0;
      end
    end else if (CLK_EN && CAPTURE.valid) begin
      h_rec_r[wr_index] <= wr_rec;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      h_exp_r <= RST_WORD;
    end else if (CLK_EN && setup_hit) begin
      h_exp_r <= read_word(APB_REQ.paddr, h_rec_r[rd_index], unit_ptr_r);
    end
  end

  sequence s_answer_read(logic [11:0] a);
    PREADY && !APB_REQ.pwrite && (APB_REQ.paddr == a);
  endsequence

  sequence s_pointer_write;
    PREADY && CLK_EN && APB_REQ.pwrite && (APB_REQ.paddr == OFS_UNIT_INDEX);
  endsequence

  // setup taken, then one enabled fetch edge
  sequence s_setup_fetch;
    (CLK_EN && setup_hit) ##1 CLK_EN;
  endsequence

  a_answer_after_fetch: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_setup_fetch |=> (state_r == ST_ANSWER))
    else $error("answer state not reached after fetch");

  // a frozen cycle must not complete a transfer
  a_ready_enabled_only: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    !CLK_EN |-> !PREADY)
    else $error("ready shown while clock enable low");

  a_unit_pointer_load: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_pointer_write |=> (unit_ptr_r == $past(APB_REQ.pwdata[UNIT_PTR_BIT])))
    else $error("unit pointer did not follow bit 8");

  a_ns7_word_read: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_answer_read(OFS_NS7) |-> (PRDATA == h_exp_r) && (PRDATA[31] == 1'b0))
    else $error("seventh nanoseconds word wrong");

  a_ns8_word_read: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_answer_read(OFS_NS8) |-> (PRDATA == h_exp_r) && (PRDATA[31] == 1'b0))
    else $error("eighth nanoseconds word wrong");

  a_ns7_capture_flow: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (CLK_EN && CAPTURE.valid && !CAPTURE.eighth) |->
      (wr_index[0] == 1'b0) && (wr_rec.nanoseconds == CAPTURE.nanoseconds))
    else $error("seventh capture not routed to seventh record");

  a_ns8_capture_flow: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (CLK_EN && CAPTURE.valid && CAPTURE.eighth) |->
      (wr_index[0] == 1'b1) && (wr_rec.polarity == CAPTURE.rising))
    else $error("eighth capture not routed to eighth record");

  a_sec7_word_read: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_answer_read(OFS_SEC7) |-> (PRDATA == h_exp_r))
    else $error("seventh seconds word wrong");

  a_sec8_word_read: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_answer_read(OFS_SEC8) |-> (PRDATA == h_exp_r))
    else $error("eighth seconds word wrong");

  a_phase_word_read: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    s_answer_read(OFS_PH7) |-> (PRDATA[31:3] == 29'h0) && (PRDATA == h_exp_r))
    else $error("phase word wrong or upper bits set");

  a_slot_code_last: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (CAPTURE.valid && !CAPTURE.eighth && (CAPTURE.slot == 3'h4)) |->
      (wr_rec.phase_code == 3'h4))
    else $error("fifth slot code not 100");

  a_slot_code_third: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (CAPTURE.valid && !CAPTURE.eighth && (CAPTURE.slot == 3'h2)) |->
      (wr_rec.phase_code == 3'h2))
    else $error("third slot code not 010");

  a_write_ignored_data: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (PREADY && CLK_EN && APB_REQ.pwrite && is_sample(APB_REQ.paddr) && !CAPTURE.valid) |=>
      (h_exp_r == $past(h_exp_r)) && !PREADY)
    else $error("write to sample register had an effect");

endmodule // etsss_top

// ### testbench/etsss_bench.sv
// self-checking bench for the event timestamp sample store
`timescale 1ns/10ps
module event_timestamp_sample_store_bench;
  import etsss_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic           clk;        // bench clock, 8 ns
  logic           rstn;       // active low reset
  logic           clk_en;     // clock enable, high except during the t_stall windows
  etsss_apb_req_t req;        // apb request carrier
  logic           pready;     // apb ready
  logic [31:0]    prdata;     // apb read data
  logic           pslverr;    // apb error
  etsss_capture_t cap;        // capture carrier
  logic           unit_ptr;   // unit pointer output
  int             num_errors; // mismatch count
  int             checks;     // comparison count
  int             cycles = 0; // timeout counter

  // ==========================================================
  // design under test
  etsss_top uut (
    .CLOCK(clk), .RSTN(rstn), .CLK_EN(clk_en), .APB_REQ(req), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .CAPTURE(cap), .UNIT_POINTER(unit_ptr)
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard: far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // shared tasks
  // prints counts and verdict, then stops
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // compares one word
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er, output int nw);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    nw = 0;
    // values read at a rising edge are those settled before it
    do begin
      @(posedge clk);
      nw++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // read and compare data, expect no error
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic        er;
    int          nw;
    apb(1'b0, a, 32'h0000_0000, d, er, nw);
    chk(nm, e, d);
    chk({nm, " err"}, 32'h0000_0000, {31'h0, er});
    chk({nm, " delay"}, 32'h0000_0002, 32'(nw));
  endtask

  // write, expect no error
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        er;
    int          nw;
    apb(1'b1, a, wd, d, er, nw);
    chk("write err", 32'h0000_0000, {31'h0, er});
  endtask

  // one-cycle capture strobe
  task automatic capture(input logic u, input logic e8, input logic ri,
                         input logic [29:0] ns, input logic [31:0] s, input logic [2:0] sl);
    @(posedge clk);
    cap <= '{valid: 1'b1, unit: u, eighth: e8, rising: ri, nanoseconds: ns,
             seconds: s, slot: sl};
    @(posedge clk);
    cap.valid <= 1'b0;
  endtask

  // ==========================================================
  // scenarios
  // every sample register reads zero after reset, pointer output zero
  task automatic t_reset();
    rd_chk(OFS_NS7, 32'h0000_0000, "ns7 reset");
    rd_chk(OFS_SEC7, 32'h0000_0000, "sec7 reset");
    rd_chk(OFS_PH7, 32'h0000_0000, "ph7 reset");
    rd_chk(OFS_NS8, 32'h0000_0000, "ns8 reset");
    rd_chk(OFS_SEC8, 32'h0000_0000, "sec8 reset");
    chk("pointer reset", 32'h0000_0000, {31'h0, unit_ptr});
    $display("t_reset done");
  endtask

  // seventh sample, rising edge, third slot
  task automatic t_seventh();
    capture(1'b0, 1'b0, 1'b1, 30'h0000_0005, 32'h1234_5678, 3'h2);
    rd_chk(OFS_NS7, 32'h4000_0005, "ns7 word");
    rd_chk(OFS_SEC7, 32'h1234_5678, "sec7 word");
    rd_chk(OFS_PH7, 32'h0000_0002, "ph7 slot2");
    $display("t_seventh done");
  endtask

  // each slot maps to its code; full ns field, falling edge
  task automatic t_codes();
    // slots 5..7 are out of range and read as the first slot's code
    logic [2:0] code [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0};
    logic [2:0] sl;
    for (int s = 0; s < 8; s++) begin
      sl = 3'(s + 5);
      capture(1'b0, 1'b0, 1'b0, 30'h3fff_ffff, 32'(sl), sl);
      rd_chk(OFS_PH7, {29'h0, code[sl]}, "ph7 code");
      rd_chk(OFS_NS7, 32'h3fff_ffff, "ns7 falling");
    end
    $display("t_codes done");
  endtask

  // eighth sample on unit one, selected by the pointer
  task automatic t_eighth();
    capture(1'b1, 1'b1, 1'b0, 30'h2aaa_aaaa, 32'hdead_beef, 3'h1);
    rd_chk(OFS_NS8, 32'h0000_0000, "ns8 unit0");
    wr_chk(OFS_UNIT_INDEX, 32'hffff_ffff);
    rd_chk(OFS_UNIT_INDEX, 32'h0000_0100, "index word");
    chk("pointer set", 32'h0000_0001, {31'h0, unit_ptr});
    rd_chk(OFS_NS8, 32'h2aaa_aaaa, "ns8 falling");
    rd_chk(OFS_SEC8, 32'hdead_beef, "sec8 word");
    capture(1'b1, 1'b1, 1'b1, 30'h0000_0001, 32'h0000_0002, 3'h0);
    rd_chk(OFS_NS8, 32'h4000_0001, "ns8 rising");
    rd_chk(OFS_SEC7, 32'h0000_0000, "sec7 unit1");
    wr_chk(OFS_UNIT_INDEX, 32'hffff_feff);
    rd_chk(OFS_SEC7, 32'h0000_0004, "sec7 unit0");
    $display("t_eighth done");
  endtask

  // writes are ignored, unmapped access errors
  task automatic t_writes();
    logic [31:0] d;
    logic        er;
    int          nw;
    wr_chk(OFS_NS7, 32'hffff_ffff);
    wr_chk(OFS_PH7, 32'hffff_ffff);
    wr_chk(OFS_SEC8, 32'h0000_0000);
    rd_chk(OFS_NS7, 32'h3fff_ffff, "ns7 after write");
    rd_chk(OFS_PH7, 32'h0000_0004, "ph7 after write");
    apb(1'b0, 12'h5b8, 32'h0000_0000, d, er, nw);
    chk("unmapped err", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, d);
    $display("t_writes done");
  endtask

  // clock enable low for len edges, from k edges after the call, stretches a read
  task automatic t_stall(input int k, input int len, input logic [11:0] a,
                         input logic [31:0] e);
    logic [31:0] d;
    logic        er;
    int          nw;
    fork
      apb(1'b0, a, 32'h0000_0000, d, er, nw);
      begin
        repeat (k) @(posedge clk);
        clk_en <= 1'b0;
        repeat (len) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    chk("stalled read", e, d);
    chk("stalled delay", 32'(2 + len), 32'(nw));
    $display("t_stall done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rstn       = 1'b0;
    clk_en     = 1'b1;
    req        = '0;
    cap        = '0;
    num_errors = 0;
    checks     = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_seventh();
    t_codes();
    t_eighth();
    t_writes();
    t_stall(1, 1, OFS_SEC7, 32'h0000_0004);
    t_stall(3, 2, OFS_NS7, 32'h3fff_ffff);
    complete_run();
  end
endmodule // event_timestamp_sample_store_bench
